// >>> cefa_pkg.sv
// Constants and types shared by the engine fault alarm mask block.
package cefa_pkg;

    // ****************************************************************
    // Bus and widths
    // ****************************************************************
    localparam int AW = 8;
    localparam int DW = 32;
    localparam int NEV = 10;
    localparam int MW = 16;
    localparam int BW = 8;

    // ****************************************************************
    // Register offsets
    // ****************************************************************
    localparam logic [AW-1:0] OFF_MASK = 8'h00;
    localparam logic [AW-1:0] OFF_LINK_MODE = 8'h04;
    localparam logic [AW-1:0] OFF_DEV_ADDR = 8'h08;
    localparam logic [AW-1:0] OFF_CNT_CFG = 8'h0C;
    localparam logic [AW-1:0] OFF_STATUS = 8'h10;
    localparam logic [AW-1:0] OFF_CLEAR = 8'h14;
    localparam logic [AW-1:0] OFF_IRQ_EN = 8'h18;
    localparam logic [AW-1:0] OFF_OUT_STAT = 8'h1C;

    // ****************************************************************
    // Alarm mask bit positions
    // ****************************************************************
    localparam int MB_LOW_OIL = 0;
    localparam int MB_MIN_OIL = 1;
    localparam int MB_HIGH_TEMP = 2;
    localparam int MB_MAX_TEMP = 3;
    localparam int MB_WIF = 8;
    localparam int MB_RED_CLASS = 13;
    localparam int MB_YELLOW = 14;
    localparam int MB_RED = 15;

    // ****************************************************************
    // Event positions in status, clear and enable registers
    // ****************************************************************
    localparam int EV_MIN_OIL = 0;
    localparam int EV_LOW_OIL = 1;
    localparam int EV_HIGH_TEMP = 2;
    localparam int EV_MAX_TEMP = 3;
    localparam int EV_WIF = 4;
    localparam int EV_YELLOW = 5;
    localparam int EV_RED = 6;
    localparam int EV_BUS_OFF = 7;
    localparam int EV_DUP_ADDR = 8;
    localparam int EV_COUNT = 9;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [MW-1:0] MASK_RST = 16'hFFFF;
    localparam logic [BW-1:0] LINK_MODE_RST = 8'h00;
    localparam logic [BW-1:0] DEV_ADDR_RST = 8'h01;
    localparam logic [BW-1:0] CNT_CFG_RST = 8'h00;
    localparam logic [NEV-1:0] IRQ_EN_RST = 10'h000;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_KHZ = 200000;
    localparam int COUNT_HOLD_MS = 2000;
    localparam int COUNT_HOLD_CYC = COUNT_HOLD_MS * CLK_KHZ;

    typedef enum logic [1:0] {
        CM_IDLE = 2'b00,
        CM_TIMING = 2'b01,
        CM_FIRED = 2'b10
    } cefa_cm_state_t;

endpackage

// >>> cefa_evt_if.sv
// Interface joining the event sources to the latched flag bank.
`timescale 1ns/1ps
interface cefa_evt_if;
    import cefa_pkg::*;
    logic [NEV-1:0] set;
    logic [NEV-1:0] clr;
    logic [NEV-1:0] flags;
    modport src (output set, output clr, input flags);
    modport bank (input set, input clr, output flags);
endinterface

// >>> cefa_sticky.sv
// Latched event flags: set by hardware, acknowledged by software.
`timescale 1ns/1ps
module cefa_sticky (
    input wire logic sys_clk, // System clock.
    input wire logic resetn, // Synchronous reset, active low.
    input wire logic clk_en, // Freezes all state while low.
    cefa_evt_if.bank ev // Set, clear and flag vectors.
);
    import cefa_pkg::*;

    logic [NEV-1:0] flags_r;
    wire logic [NEV-1:0] flags_nxt;

    // A set in the same cycle as its clear wins.
    assign flags_nxt = ev.set | (flags_r & ~ev.clr);
    assign ev.flags = flags_r;

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            flags_r <= '0;
        end else if (clk_en) begin
            flags_r <= flags_nxt;
        end
    end

    chk_flag_holds: assert property (@(posedge sys_clk)
        disable iff (!resetn)
        clk_en && flags_r[0] && !ev.clr[0] |=> flags_r[0])
        else $error("Latched flag dropped without acknowledge.");

    chk_set_beats_clr: assert property (@(posedge sys_clk)
        disable iff (!resetn)
        clk_en && ev.set[EV_COUNT] && ev.clr[EV_COUNT] |=> flags_r[EV_COUNT])
        else $error("Clear beat a simultaneous set.");

endmodule

// >>> cefa_cnt_mon.sv
// Watches the controller count on the link for a two second mismatch.
`timescale 1ns/1ps
module cefa_cnt_mon #(
    parameter int unsigned HOLD_CYC = cefa_pkg::COUNT_HOLD_CYC
) (
    input wire logic sys_clk, // System clock.
    input wire logic resetn, // Synchronous reset, active low.
    input wire logic clk_en, // Freezes all state while low.
    input wire logic [cefa_pkg::BW-1:0] cfg_count, // Configured count.
    input wire logic [cefa_pkg::BW-1:0] seen_count, // Controllers heard.
    input wire logic tie_open, // A bus tie breaker is open.
    output logic timeout // Mismatch has lasted the full window.
);
    import cefa_pkg::*;

    cefa_cm_state_t state_r;
    cefa_cm_state_t state_nxt;
    logic [31:0] cnt_r;
    wire logic active;
    wire logic last;

    assign active = (cfg_count != '0) && !tie_open
        && (seen_count != cfg_count);
    assign last = (cnt_r == 32'(HOLD_CYC - 1));
    assign timeout = (state_r == CM_FIRED) && active;

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            CM_IDLE: if (active) state_nxt = CM_TIMING;
            CM_TIMING: begin
                if (!active) state_nxt = CM_IDLE;
                else if (last) state_nxt = CM_FIRED;
            end
            CM_FIRED: if (!active) state_nxt = CM_IDLE;
            default: state_nxt = CM_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            state_r <= CM_IDLE;
            cnt_r <= '0;
        end else if (clk_en) begin
            state_r <= state_nxt;
            cnt_r <= (state_nxt == CM_TIMING) ? cnt_r + 32'd1 : '0;
        end
    end

    chk_tie_blocks: assert property (@(posedge sys_clk)
        disable iff (!resetn)
        clk_en && tie_open |=> !timeout)
        else $error("Count mismatch fired while a tie was open.");

endmodule

// >>> cefa_top.sv
// Engine fault alarm masking and link supervision, with APB registers.
//
// Notes on behaviour
// - Minimum oil pressure raises an alarm only while mask bit 1 is set.
// - Low oil pressure raises a warning only while mask bit 0 is set.
// - High oil temperature raises a warning only while mask bit 2 set.
// - Maximum oil temperature raises an alarm only while mask bit 3 set.
// - Water in fuel raises a warning only while mask bit 8 is set.
// - Yellow lamp raises a warning only while mask bit 14 is set.
// - Red lamp enabled by mask bit 15; bit 13 picks alarm or warning.
// - An enabled event rises as soon as the engine unit reports it.
// - Lamp events come from the engine unit or the voltage regulator.
// - Every event except bus-off is evaluated in every operating mode.
// - Link bus-off raises a warning; it has no disable bit.
// - Bus-off warning is suppressed while the link bus mode is zero.
// - A link message bearing our own address raises a warning.
// - Controller count differing two seconds warns; zero count disables.
// - Controller count warning is suppressed while a tie breaker is open.
`timescale 1ns/1ps
module cefa_top #(
    parameter int unsigned COUNT_HOLD = cefa_pkg::COUNT_HOLD_CYC
) (
    input wire logic sys_clk, // System clock, 200 MHz.
    input wire logic resetn, // Synchronous reset, active low.
    input wire logic clk_en, // Freezes all state while low.
    input wire logic psel, // APB select.
    input wire logic penable, // APB enable.
    input wire logic pwrite, // APB direction, high for write.
    input wire logic [cefa_pkg::AW-1:0] paddr, // APB byte address.
    input wire logic [cefa_pkg::DW-1:0] pwdata, // APB write data.
    output logic [cefa_pkg::DW-1:0] prdata, // APB read data.
    output logic pready, // APB ready.
    output logic pslverr, // APB error on unmapped address.
    input wire logic ecu_min_oil, // Engine unit: minimum oil pressure.
    input wire logic ecu_low_oil, // Engine unit: low oil pressure.
    input wire logic ecu_high_oil_temp, // Engine unit: high oil temp.
    input wire logic ecu_max_oil_temp, // Engine unit: maximum oil temp.
    input wire logic ecu_water_in_fuel, // Engine unit: water in fuel.
    input wire logic ecu_yellow_lamp, // Engine unit: yellow lamp.
    input wire logic avr_yellow_lamp, // Regulator: yellow lamp.
    input wire logic ecu_red_lamp, // Engine unit: red lamp.
    input wire logic avr_red_lamp, // Regulator: red lamp.
    input wire logic link_bus_off, // Link protocol engine is bus-off.
    input wire logic link_rx_valid, // One-cycle strobe per link message.
    input wire logic [cefa_pkg::BW-1:0] link_rx_addr, // Sender address.
    input wire logic [cefa_pkg::BW-1:0] link_ctrl_seen, // Count heard.
    input wire logic tie_breaker_open, // Some bus tie breaker is open.
    output logic alarm_out, // A latched alarm-class event is present.
    output logic warning_out, // A latched warning-class event is present.
    output logic irq // Level interrupt.
);
    import cefa_pkg::*;

    // ****************************************************************
    // Mask gating helper
    // ****************************************************************

    // Returns the report only while its mask bit is set.
    function automatic logic gate(
        input logic [MW-1:0] mask,
        input int pos,
        input logic report
    );
        gate = report & mask[pos];
    endfunction

    // ****************************************************************
    // Registers
    // ****************************************************************

    logic [MW-1:0] mask_r;
    logic [BW-1:0] link_mode_r;
    logic [BW-1:0] dev_addr_r;
    logic [BW-1:0] cnt_cfg_r;
    logic [NEV-1:0] irq_en_r;
    logic [DW-1:0] prdata_r;
    logic alarm_r;
    logic warning_r;
    logic irq_r;

    // ****************************************************************
    // APB decode
    // ****************************************************************

    wire logic setup_ph;
    wire logic access_ph;
    wire logic wr_take;
    wire logic hit_mask;
    wire logic hit_mode;
    wire logic hit_addr;
    wire logic hit_cnt;
    wire logic hit_status;
    wire logic hit_clear;
    wire logic hit_irq_en;
    wire logic hit_out;
    wire logic mapped;

    assign setup_ph = psel && !penable;
    assign access_ph = psel && penable;
    assign hit_mask = (paddr == OFF_MASK);
    assign hit_mode = (paddr == OFF_LINK_MODE);
    assign hit_addr = (paddr == OFF_DEV_ADDR);
    assign hit_cnt = (paddr == OFF_CNT_CFG);
    assign hit_status = (paddr == OFF_STATUS);
    assign hit_clear = (paddr == OFF_CLEAR);
    assign hit_irq_en = (paddr == OFF_IRQ_EN);
    assign hit_out = (paddr == OFF_OUT_STAT);
    assign mapped = hit_mask | hit_mode | hit_addr | hit_cnt
        | hit_status | hit_clear | hit_irq_en | hit_out;

    // The slave answers in the first access cycle.
    assign pready = 1'b1;
    assign pslverr = access_ph && !mapped;
    assign wr_take = access_ph && pwrite && mapped && clk_en;
    assign prdata = prdata_r;

    // ****************************************************************
    // Event gating
    // ****************************************************************

    cefa_evt_if ev ();

    wire logic yellow_src;
    wire logic red_src;
    wire logic bus_off_evt;
    wire logic dup_evt;
    wire logic cnt_timeout;
    wire logic [NEV-1:0] alarm_class;
    wire logic [NEV-1:0] clr_vec;

    // No operating mode term appears: all events but bus-off are live in all modes.
    assign yellow_src = ecu_yellow_lamp | avr_yellow_lamp;
    assign red_src = ecu_red_lamp | avr_red_lamp;

    // Reports pass straight to the flags with no delay or filter.
    assign ev.set[EV_MIN_OIL] =
        gate(mask_r, MB_MIN_OIL, ecu_min_oil);
    assign ev.set[EV_LOW_OIL] =
        gate(mask_r, MB_LOW_OIL, ecu_low_oil);
    assign ev.set[EV_HIGH_TEMP] =
        gate(mask_r, MB_HIGH_TEMP, ecu_high_oil_temp);
    assign ev.set[EV_MAX_TEMP] =
        gate(mask_r, MB_MAX_TEMP, ecu_max_oil_temp);
    assign ev.set[EV_WIF] =
        gate(mask_r, MB_WIF, ecu_water_in_fuel);
    assign ev.set[EV_YELLOW] =
        gate(mask_r, MB_YELLOW, yellow_src);
    assign ev.set[EV_RED] =
        gate(mask_r, MB_RED, red_src);

    assign bus_off_evt = link_bus_off
        && (link_mode_r != '0);
    assign dup_evt = link_rx_valid
        && (link_rx_addr == dev_addr_r);

    assign ev.set[EV_BUS_OFF] = bus_off_evt;
    assign ev.set[EV_DUP_ADDR] = dup_evt;
    assign ev.set[EV_COUNT] = cnt_timeout;

    // Writing ones to the clear register acknowledges those flags.
    assign clr_vec = pwdata[NEV-1:0];
    assign ev.clr = (wr_take && hit_clear) ? clr_vec : '0;

    // Red lamp class follows its class bit; the rest are fixed.
    assign alarm_class = {
        3'b000,
        mask_r[MB_RED_CLASS],
        2'b00,
        1'b1,
        2'b00,
        1'b1
    };

    // ****************************************************************
    // Sub-blocks
    // ****************************************************************

    cefa_sticky u_sticky (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .clk_en(clk_en),
        .ev(ev.bank)
    );

    cefa_cnt_mon #(
        .HOLD_CYC(COUNT_HOLD)
    ) u_cnt_mon (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .clk_en(clk_en),
        .cfg_count(cnt_cfg_r),
        .seen_count(link_ctrl_seen),
        .tie_open(tie_breaker_open),
        .timeout(cnt_timeout)
    );

    // ****************************************************************
    // Read data selection
    // ****************************************************************

    wire logic [NEV-1:0] flags;
    wire logic [DW-1:0] rd_data;
    wire logic any_alarm;
    wire logic any_warning;
    wire logic any_irq;

    assign flags = ev.flags;
    assign any_alarm = |(flags & alarm_class);
    assign any_warning = |(flags & ~alarm_class);
    assign any_irq = |(flags & irq_en_r);

    assign rd_data =
        hit_mask ? {16'h0000, mask_r} :
        hit_mode ? {24'h000000, link_mode_r} :
        hit_addr ? {24'h000000, dev_addr_r} :
        hit_cnt ? {24'h000000, cnt_cfg_r} :
        hit_status ? {22'h0, flags} :
        hit_irq_en ? {22'h0, irq_en_r} :
        hit_out ? {29'h0, irq_r, warning_r, alarm_r} :
        32'h00000000;

    // ****************************************************************
    // Register writes and outputs
    // ****************************************************************

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            mask_r <= MASK_RST;
            link_mode_r <= LINK_MODE_RST;
            dev_addr_r <= DEV_ADDR_RST;
            cnt_cfg_r <= CNT_CFG_RST;
            irq_en_r <= IRQ_EN_RST;
        end else if (wr_take) begin
            if (hit_mask) mask_r <= pwdata[MW-1:0];
            if (hit_mode) link_mode_r <= pwdata[BW-1:0];
            if (hit_addr) dev_addr_r <= pwdata[BW-1:0];
            if (hit_cnt) cnt_cfg_r <= pwdata[BW-1:0];
            if (hit_irq_en) irq_en_r <= pwdata[NEV-1:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            prdata_r <= '0;
        end else if (clk_en && setup_ph && !pwrite) begin
            prdata_r <= rd_data;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            alarm_r <= 1'b0;
            warning_r <= 1'b0;
            irq_r <= 1'b0;
        end else if (clk_en) begin
            alarm_r <= any_alarm;
            warning_r <= any_warning;
            irq_r <= any_irq;
        end
    end

    assign alarm_out = alarm_r;
    assign warning_out = warning_r;
    assign irq = irq_r;

    // ****************************************************************
    // Checks
    // ****************************************************************

    default clocking cb @(posedge sys_clk);
    endclocking

    default disable iff (!resetn);

    chk_min_oil_on: assert property (
        clk_en && ecu_min_oil && mask_r[MB_MIN_OIL] |=>
        flags[EV_MIN_OIL] ##1 (alarm_r || !$past(clk_en)))
        else $error("Enabled minimum oil pressure not latched as alarm.");

    chk_min_oil_off: assert property (
        clk_en && !mask_r[MB_MIN_OIL] && !flags[EV_MIN_OIL] |=>
        !flags[EV_MIN_OIL])
        else $error("Masked minimum oil pressure was latched.");

    chk_low_oil_gate: assert property (
        clk_en && !flags[EV_LOW_OIL] |=>
        flags[EV_LOW_OIL] == $past(ecu_low_oil && mask_r[MB_LOW_OIL]))
        else $error("Low oil pressure gating wrong.");

    chk_high_temp_gate: assert property (
        clk_en && !flags[EV_HIGH_TEMP] |=>
        flags[EV_HIGH_TEMP] ==
        $past(ecu_high_oil_temp && mask_r[MB_HIGH_TEMP]))
        else $error("High oil temperature gating wrong.");

    chk_max_temp_gate: assert property (
        clk_en && !flags[EV_MAX_TEMP] |=>
        flags[EV_MAX_TEMP] ==
        $past(ecu_max_oil_temp && mask_r[MB_MAX_TEMP]))
        else $error("Maximum oil temperature gating wrong.");

    chk_max_temp_alarm: assert property (
        clk_en && flags[EV_MAX_TEMP] |=> alarm_r)
        else $error("Maximum oil temperature did not drive alarm.");

    chk_wif_gate: assert property (
        clk_en && !flags[EV_WIF] |=>
        flags[EV_WIF] ==
        $past(ecu_water_in_fuel && mask_r[MB_WIF]))
        else $error("Water in fuel gating wrong.");

    chk_yellow_avr: assert property (
        clk_en && avr_yellow_lamp && mask_r[MB_YELLOW] |=>
        flags[EV_YELLOW])
        else $error("Regulator yellow lamp not latched.");

    chk_red_class: assert property (
        clk_en && flags[EV_RED] && mask_r[MB_RED_CLASS] |=>
        alarm_r)
        else $error("Red lamp with alarm class did not drive alarm.");

    chk_red_warning: assert property (
        clk_en && flags[EV_RED] && !mask_r[MB_RED_CLASS] |=> warning_r)
        else $error("Red lamp with warning class did not drive warning.");

    chk_red_avr: assert property (
        clk_en && avr_red_lamp && mask_r[MB_RED] |=>
        flags[EV_RED])
        else $error("Regulator red lamp not latched.");

    chk_bus_off_set: assert property (
        clk_en && link_bus_off && link_mode_r != '0 |=>
        flags[EV_BUS_OFF])
        else $error("Bus-off not latched.");

    chk_bus_off_mute: assert property (
        clk_en && link_mode_r == '0 && !flags[EV_BUS_OFF] |=>
        !flags[EV_BUS_OFF])
        else $error("Bus-off latched with bus mode zero.");

    chk_dup_addr: assert property (
        clk_en && link_rx_valid && link_rx_addr == dev_addr_r |=>
        flags[EV_DUP_ADDR])
        else $error("Own address on link not flagged.");

    chk_count_off: assert property (
        clk_en && cnt_cfg_r == '0 && !flags[EV_COUNT] |=>
        !flags[EV_COUNT])
        else $error("Count warning with zero configured count.");

    chk_irq_level: assert property (
        clk_en && (flags & irq_en_r) != '0 |=> irq)
        else $error("Enabled flag did not raise the interrupt.");

    chk_unmapped_err: assert property (
        access_ph && !mapped |-> pslverr && pready)
        else $error("Unmapped access not answered with error.");

endmodule

// >>> cefa_far_model.sv
// Far-side model: engine unit and regulator fault reports.
`timescale 1ns/1ps
module cefa_far_model (
    input wire logic sys_clk, // System clock.
    input wire logic [8:0] rep, // Reports requested by the bench.
    output logic [8:0] lines // Reports as the far side drives them.
);
    initial lines = 9'h000;
    // Reports change only just after a clock edge, as a real sender would.
    always @(posedge sys_clk) begin
        lines <= rep;
    end
endmodule

// >>> tb.sv
// Self-checking bench for the engine fault alarm mask block.
`timescale 1ns/1ps
module tb;
    import cefa_pkg::*;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [AW-1:0] paddr = 8'h00;
    logic [DW-1:0] pwdata = 32'h0;
    logic [DW-1:0] prdata, rd;
    logic pready, pslverr, alarm_out, warning_out, irq, er;
    logic [8:0] rep = 9'h000;
    logic [8:0] ln, r;
    logic bus_off = 1'b0, rx_v = 1'b0, tie = 1'b0;
    logic [BW-1:0] rx_a = 8'h00, seen = 8'h02;
    logic [15:0] m;
    logic [2:0] o;
    logic [9:0] en, st;
    int mismatches = 0, tests_run = 0, seed = 3738;
    always #2.5 sys_clk = ~sys_clk;
    cefa_far_model u_cefa_far_model (.sys_clk(sys_clk), .rep(rep),
        .lines(ln));
    cefa_top #(.COUNT_HOLD(20)) u_cefa_top (.sys_clk(sys_clk),
        .resetn(resetn), .clk_en(1'b1), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ecu_min_oil(ln[0]),
        .ecu_low_oil(ln[1]), .ecu_high_oil_temp(ln[2]),
        .ecu_max_oil_temp(ln[3]), .ecu_water_in_fuel(ln[4]),
        .ecu_yellow_lamp(ln[5]), .avr_yellow_lamp(ln[6]),
        .ecu_red_lamp(ln[7]), .avr_red_lamp(ln[8]),
        .link_bus_off(bus_off), .link_rx_valid(rx_v), .link_rx_addr(rx_a),
        .link_ctrl_seen(seen), .tie_breaker_open(tie),
        .alarm_out(alarm_out), .warning_out(warning_out), .irq(irq));
    function automatic logic [9:0] exp_st(input logic [15:0] k,
        input logic [8:0] s);
        exp_st = 10'h000;
        exp_st[0] = s[0] & k[1];
        exp_st[1] = s[1] & k[0];
        exp_st[2] = s[2] & k[2];
        exp_st[3] = s[3] & k[3];
        exp_st[4] = s[4] & k[8];
        exp_st[5] = (s[5] | s[6]) & k[14];
        exp_st[6] = (s[7] | s[8]) & k[15];
    endfunction
    function automatic logic [2:0] exp_out(input logic [15:0] k,
        input logic [9:0] f, input logic [9:0] e);
        exp_out[0] = f[0] | f[3] | (f[6] & k[13]);
        exp_out[1] = f[1] | f[2] | f[4] | f[5] | (|f[9:7])
            | (f[6] & ~k[13]);
        exp_out[2] = |(f & e);
    endfunction
    task automatic chk(input logic [DW-1:0] g, input logic [DW-1:0] e);
        tests_run++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask
    task automatic apb(input logic w, input logic [AW-1:0] a,
        input logic [DW-1:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdc(input logic [AW-1:0] a, input logic [DW-1:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask
    task automatic pulse(input logic [BW-1:0] a);
        rx_a <= a;
        rx_v <= 1'b1;
        @(posedge sys_clk);
        rx_v <= 1'b0;
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge sys_clk);
        mismatches++;
        report_and_stop();
    end
    initial begin
        repeat (20) @(posedge sys_clk);
        resetn <= 1'b1;
        rdc(OFF_MASK, 32'h0000FFFF);
        rdc(OFF_DEV_ADDR, 32'h00000001);
        rdc(OFF_OUT_STAT, 32'h0);
        apb(1'b0, 8'h20, 32'h0);
        chk({31'h0, er}, 32'h1);
        apb(1'b1, OFF_STATUS, 32'hFFFFFFFF);
        rdc(OFF_STATUS, 32'h0);
        $display("test registers done");
        for (int i = 0; i < 24; i++) begin
            r = (i < 18) ? 9'h001 << (i % 9) : 9'($random(seed));
            m = (i < 9) ? {2'b11, i[0], 13'h1FFF} : 16'($random(seed));
            en = 10'($random(seed));
            apb(1'b1, OFF_MASK, {16'h0, m});
            apb(1'b1, OFF_IRQ_EN, {22'h0, en});
            apb(1'b1, OFF_CLEAR, 32'h3FF);
            rdc(OFF_STATUS, 32'h0);
            rep <= r;
            repeat (3) @(posedge sys_clk);
            rep <= 9'h000;
            st = exp_st(m, r);
            rdc(OFF_STATUS, {22'h0, st});
            o = exp_out(m, st, en);
            rdc(OFF_OUT_STAT, {29'h0, o});
            chk({29'h0, irq, warning_out, alarm_out}, {29'h0, o});
        end
        $display("test engine events done");
        apb(1'b1, OFF_CLEAR, 32'h3FF);
        bus_off <= 1'b1;
        repeat (4) @(posedge sys_clk);
        rdc(OFF_STATUS, 32'h0);
        apb(1'b1, OFF_LINK_MODE, 32'h1);
        repeat (4) @(posedge sys_clk);
        rdc(OFF_STATUS, 32'h80);
        bus_off <= 1'b0;
        apb(1'b1, OFF_CLEAR, 32'h80);
        pulse(8'h05);
        rdc(OFF_STATUS, 32'h0);
        pulse(8'h01);
        rdc(OFF_STATUS, 32'h100);
        $display("test link done");
        apb(1'b1, OFF_CLEAR, 32'h3FF);
        tie <= 1'b1;
        apb(1'b1, OFF_CNT_CFG, 32'h3);
        repeat (40) @(posedge sys_clk);
        rdc(OFF_STATUS, 32'h0);
        tie <= 1'b0;
        repeat (8) @(posedge sys_clk);
        rdc(OFF_STATUS, 32'h0);
        repeat (20) @(posedge sys_clk);
        rdc(OFF_STATUS, 32'h200);
        apb(1'b1, OFF_CLEAR, 32'h3FF);
        rdc(OFF_STATUS, 32'h200);
        apb(1'b1, OFF_CNT_CFG, 32'h0);
        apb(1'b1, OFF_CLEAR, 32'h3FF);
        rdc(OFF_STATUS, 32'h0);
        $display("test controller count done");
        report_and_stop();
    end
endmodule
